// ### src/crs_pkg.sv
// Shared constants and types for the CPU register set.
package crs_pkg;
	// ==========================================================
	// Widths
	localparam int unsigned CRS_DW = 32; // Register width
	localparam int unsigned CRS_AW = 5; // Register port address width
	localparam int unsigned CRS_MACW = 64; // Multiply-accumulate width
	localparam int unsigned CRS_FPN = 5; // Floating-point exception count
	localparam int unsigned CRS_EVN = 3; // Interrupt event count
	// ==========================================================
	// Register port indices
	localparam logic [4:0] CRS_A_GPR0 = 5'h00; // Active stack pointer
	localparam logic [4:0] CRS_A_ISTK = 5'h10; // Interrupt stack pointer
	localparam logic [4:0] CRS_A_USTK = 5'h11; // User stack pointer
	localparam logic [4:0] CRS_A_VTB = 5'h12; // Vector table base
	localparam logic [4:0] CRS_A_PC = 5'h13;
	localparam logic [4:0] CRS_A_STW = 5'h14; // Status word
	localparam logic [4:0] CRS_A_SVPC = 5'h15; // Saved program counter
	localparam logic [4:0] CRS_A_SVSTW = 5'h16; // Saved status word
	localparam logic [4:0] CRS_A_FVEC = 5'h17; // Fast vector address
	localparam logic [4:0] CRS_A_FPST = 5'h18; // Floating-point status word
	localparam logic [4:0] CRS_A_MACHI = 5'h19; // Bits 63..32
	localparam logic [4:0] CRS_A_MACLO = 5'h1a; // Read and write bits 31..0
	localparam logic [4:0] CRS_A_MACMI = 5'h1b; // Read bits 47..16
	localparam logic [4:0] CRS_A_IRQST = 5'h1c; // Read clears
	localparam logic [4:0] CRS_A_IRQMSK = 5'h1d;
	// ==========================================================
	// Field positions
	localparam int unsigned CRS_STW_U = 17; // Stack select bit
	localparam int unsigned CRS_FP_C = 0; // Cause flags base
	localparam int unsigned CRS_FP_E = 5; // Trap enables base
	localparam int unsigned CRS_FP_F = 10; // Sticky flags base
	localparam int unsigned CRS_EV_FINT = 0; // Fast interrupt taken
	localparam int unsigned CRS_EV_FPTRAP = 1; // Enabled FP exception
	localparam int unsigned CRS_EV_FPMSK = 2; // Masked FP exception
	// ==========================================================
	// Reset values
	localparam logic [31:0] CRS_RST_WORD = 32'h0000_0000;
	localparam logic [63:0] CRS_RST_MAC = 64'h0000_0000_0000_0000;
	localparam logic [2:0] CRS_RST_MSK = 3'h0;
	// ==========================================================
	// Carriers
	typedef struct packed {
		logic valid; // One-cycle load strobe
		logic [31:0] value; // New value
	} crs_load_t;
	typedef struct packed {
		logic valid; // Product-type instruction retires
		logic [63:0] result; // Full accumulator result
	} crs_mac_t;
endpackage : crs_pkg

// ### src/crs_register_set.sv
// CPU architectural register set with register port and interrupt flags.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Sixteen general, nine control, one accumulator register
// - General registers one to fifteen interchangeable
// - Register zero is the active stack pointer
// - Stack select bit picks interrupt or user pointer
// - Vector table base holds table start address
// - Program counter holds executing instruction address
// - Fast interrupt saves program counter copy
// - Fast interrupt saves status word copy
// - Fast interrupt branches to fast vector address
// - Enabled exception sets its cause flag
// - Disabled exception is masked, no handler
// - Sticky exception flags accumulate until cleared
// - Accumulator is 64 bits, DSP destination
// - Product instructions overwrite the accumulator
// - Move-to writes high or low half
// - Move-from reads high, middle or low word
module crs_register_set (
	input wire logic SYS_CLK_IN,
	input wire logic ARST_N_IN,
	input wire logic [crs_pkg::CRS_AW-1:0] ADDR_IN,
	input wire logic [crs_pkg::CRS_DW-1:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire crs_pkg::crs_load_t PC_LOAD_IN,
	input wire logic FINT_ACCEPT_IN,
	input wire crs_pkg::crs_mac_t MAC_OP_IN,
	input wire logic [crs_pkg::CRS_FPN-1:0] FP_EXC_IN,
	output logic [crs_pkg::CRS_DW-1:0] RDATA_OUT,
	output logic [crs_pkg::CRS_DW-1:0] PC_OUT,
	output logic [crs_pkg::CRS_DW-1:0] STW_OUT,
	output logic [crs_pkg::CRS_DW-1:0] VTB_OUT,
	output logic [crs_pkg::CRS_DW-1:0] SP_OUT,
	output logic FINT_BRANCH_OUT,
	output logic FP_TRAP_OUT,
	output logic IRQ_OUT
);
	import crs_pkg::*;

	// ==========================================================
	// Reset release
	logic rst_s1_r; // First stage, read only by second
	logic rst_n_r; // Released reset used everywhere

	// Two flops so the release is clean against the clock
	always_ff @(posedge SYS_CLK_IN or negedge ARST_N_IN) begin
		if (!ARST_N_IN) begin
			rst_s1_r <= 1'b0;
			rst_n_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n_r <= rst_s1_r;
		end
	end

	// ==========================================================
	// Storage
	// Register zero has no storage: it aliases the selected stack pointer
	logic [31:0] gpr_r [1:15]; // General registers one to fifteen
	logic [31:0] istk_r; // Interrupt stack pointer
	logic [31:0] ustk_r; // User stack pointer
	logic [31:0] vtb_r; // Vector table base
	logic [31:0] pc_r; // Program counter
	logic [31:0] stw_r; // Status word
	logic [31:0] svpc_r; // Saved program counter
	logic [31:0] svstw_r; // Saved status word
	logic [31:0] fvec_r; // Fast vector address
	logic [4:0] fp_cause_r; // Cause flags
	logic [4:0] fp_en_r; // Trap enables
	logic [4:0] fp_sticky_r; // Accumulating flags
	logic [63:0] mac_r; // Multiply-accumulate register
	logic [2:0] irq_sts_r; // Sticky event bits
	logic [2:0] irq_msk_r; // Event mask
	logic [2:0] ev_nxt; // Events of this cycle

	// Decode one register-port index, used by both write and read
	function automatic logic hit(input logic [4:0] a, input logic [4:0] idx);
		hit = (a == idx);
	endfunction

	logic wr_sp; // Write to active stack pointer
	logic use_ustk; // Stack select currently user
	logic fp_trap_nxt; // Enabled exception this cycle
	logic fp_any; // Any exception this cycle
	assign use_ustk = stw_r[CRS_STW_U];
	assign wr_sp = WR_IN && hit(ADDR_IN, CRS_A_GPR0);
	assign fp_any = |FP_EXC_IN;
	assign fp_trap_nxt = |(FP_EXC_IN & fp_en_r);

	// ==========================================================
	// General registers one to fifteen
	// Same storage serves data or address use; no per-register role
	genvar gi;
	generate
		for (gi = 1; gi < 16; gi++) begin : g_gpr
			always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
				if (!rst_n_r) begin
					gpr_r[gi] <= CRS_RST_WORD;
				end else if (WR_IN && hit(ADDR_IN, 5'(gi))) begin
					gpr_r[gi] <= WDATA_IN;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Stack pointers, banked behind register zero
	always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
		if (!rst_n_r) begin
			istk_r <= CRS_RST_WORD;
			ustk_r <= CRS_RST_WORD;
		end else begin
			// Direct write wins; the banked alias goes to the selected one
			// Alignment is left to software; any word value is kept as written
			if (WR_IN && hit(ADDR_IN, CRS_A_ISTK)) begin
				istk_r <= WDATA_IN;
			end else if (wr_sp && !use_ustk) begin
				istk_r <= WDATA_IN;
			end
			if (WR_IN && hit(ADDR_IN, CRS_A_USTK)) begin
				ustk_r <= WDATA_IN;
			end else if (wr_sp && use_ustk) begin
				ustk_r <= WDATA_IN;
			end
		end
	end

	// ==========================================================
	// Plain control registers
	always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
		if (!rst_n_r) begin
			vtb_r <= CRS_RST_WORD;
			stw_r <= CRS_RST_WORD;
			fvec_r <= CRS_RST_WORD;
		end else if (WR_IN) begin
			// Status word keeps its value across a fast interrupt
			if (hit(ADDR_IN, CRS_A_VTB)) begin
				vtb_r <= WDATA_IN;
			end
			if (hit(ADDR_IN, CRS_A_STW)) begin
				stw_r <= WDATA_IN;
			end
			if (hit(ADDR_IN, CRS_A_FVEC)) begin
				fvec_r <= WDATA_IN;
			end
		end
	end

	// ==========================================================
	// Program counter and fast interrupt backup
	// Fast interrupt outranks the unit's load and port writes
	always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
		if (!rst_n_r) begin
			pc_r <= CRS_RST_WORD;
			svpc_r <= CRS_RST_WORD;
			svstw_r <= CRS_RST_WORD;
		end else if (FINT_ACCEPT_IN) begin
			// Copies take the values of the interrupted instruction
			svpc_r <= pc_r;
			svstw_r <= stw_r;
			pc_r <= fvec_r;
		end else begin
			// The unit's own load outranks a port write to the counter
			if (PC_LOAD_IN.valid) begin
				pc_r <= PC_LOAD_IN.value;
			end else if (WR_IN && hit(ADDR_IN, CRS_A_PC)) begin
				pc_r <= WDATA_IN;
			end
			if (WR_IN && hit(ADDR_IN, CRS_A_SVPC)) begin
				svpc_r <= WDATA_IN;
			end
			if (WR_IN && hit(ADDR_IN, CRS_A_SVSTW)) begin
				svstw_r <= WDATA_IN;
			end
		end
	end

	// ==========================================================
	// Floating-point status word
	always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
		if (!rst_n_r) begin
			fp_cause_r <= 5'h00;
			fp_en_r <= 5'h00;
			fp_sticky_r <= 5'h00;
		end else begin
			// A port write loads all fields; a new exception replaces the cause and merges into the sticky flags
			if (WR_IN && hit(ADDR_IN, CRS_A_FPST)) begin
				fp_en_r <= WDATA_IN[CRS_FP_E +: CRS_FPN];
			end
			// Cause names the latest operation, so the handler sees its own
			if (fp_any) begin
				fp_cause_r <= FP_EXC_IN;
			end else if (WR_IN && hit(ADDR_IN, CRS_A_FPST)) begin
				fp_cause_r <= WDATA_IN[CRS_FP_C +: CRS_FPN];
			end
			// New exceptions win over a clearing write
			if (WR_IN && hit(ADDR_IN, CRS_A_FPST)) begin
				fp_sticky_r <= WDATA_IN[CRS_FP_F +: CRS_FPN] | FP_EXC_IN;
			end else begin
				fp_sticky_r <= fp_sticky_r | FP_EXC_IN;
			end
		end
	end

	// ==========================================================
	// Accumulator
	always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
		if (!rst_n_r) begin
			mac_r <= CRS_RST_MAC;
		end else if (MAC_OP_IN.valid) begin
			mac_r <= MAC_OP_IN.result;
		end else if (WR_IN && hit(ADDR_IN, CRS_A_MACHI)) begin
			mac_r[63:32] <= WDATA_IN;
		end else if (WR_IN && hit(ADDR_IN, CRS_A_MACLO)) begin
			mac_r[31:0] <= WDATA_IN;
		end
	end

	// ==========================================================
	// Read mux, registered so data stand the cycle after the strobe
	logic [31:0] rd_nxt; // Selected read value
	always_comb begin
		rd_nxt = 32'h0000_0000; // Unmapped reads as zero
		unique case (ADDR_IN)
			// Register zero reads whichever stack pointer is selected now
			CRS_A_GPR0: rd_nxt = use_ustk ? ustk_r : istk_r;
			CRS_A_ISTK: rd_nxt = istk_r;
			CRS_A_USTK: rd_nxt = ustk_r;
			CRS_A_VTB: rd_nxt = vtb_r;
			CRS_A_PC: rd_nxt = pc_r;
			CRS_A_STW: rd_nxt = stw_r;
			CRS_A_SVPC: rd_nxt = svpc_r;
			CRS_A_SVSTW: rd_nxt = svstw_r;
			CRS_A_FVEC: rd_nxt = fvec_r;
			CRS_A_FPST: begin
				rd_nxt[CRS_FP_C +: CRS_FPN] = fp_cause_r;
				rd_nxt[CRS_FP_E +: CRS_FPN] = fp_en_r;
				rd_nxt[CRS_FP_F +: CRS_FPN] = fp_sticky_r;
			end
			CRS_A_MACHI: rd_nxt = mac_r[63:32];
			CRS_A_MACLO: rd_nxt = mac_r[31:0];
			CRS_A_MACMI: rd_nxt = mac_r[47:16];
			CRS_A_IRQST: rd_nxt[2:0] = irq_sts_r;
			CRS_A_IRQMSK: rd_nxt[2:0] = irq_msk_r;
			CRS_A_IRQMSK + 5'h01,
			CRS_A_IRQMSK + 5'h02: rd_nxt = 32'h0000_0000;
			default: rd_nxt = gpr_r[ADDR_IN[3:0]];
		endcase
	end

	always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
		if (!rst_n_r) begin
			RDATA_OUT <= CRS_RST_WORD;
		end else if (RD_IN) begin
			RDATA_OUT <= rd_nxt;
		end else begin
			RDATA_OUT <= CRS_RST_WORD;
		end
	end

	// ==========================================================
	// Events, sticky status and mask
	always_comb begin
		ev_nxt = 3'h0;
		ev_nxt[CRS_EV_FINT] = FINT_ACCEPT_IN;
		ev_nxt[CRS_EV_FPTRAP] = fp_trap_nxt;
		ev_nxt[CRS_EV_FPMSK] = fp_any && !fp_trap_nxt;
	end

	// Read clears; an event in the same cycle survives
	always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
		if (!rst_n_r) begin
			irq_sts_r <= 3'h0;
			irq_msk_r <= CRS_RST_MSK;
		end else begin
			if (RD_IN && hit(ADDR_IN, CRS_A_IRQST)) begin
				irq_sts_r <= ev_nxt;
			end else begin
				irq_sts_r <= irq_sts_r | ev_nxt;
			end
			if (WR_IN && hit(ADDR_IN, CRS_A_IRQMSK)) begin
				irq_msk_r <= WDATA_IN[2:0];
			end
		end
	end

	// ==========================================================
	// Registered outputs; level interrupt lags status by one cycle
	always_ff @(posedge SYS_CLK_IN or negedge rst_n_r) begin
		if (!rst_n_r) begin
			IRQ_OUT <= 1'b0;
			FINT_BRANCH_OUT <= 1'b0;
			FP_TRAP_OUT <= 1'b0;
			PC_OUT <= CRS_RST_WORD;
			STW_OUT <= CRS_RST_WORD;
			VTB_OUT <= CRS_RST_WORD;
			SP_OUT <= CRS_RST_WORD;
		end else begin
			// Copies lag their registers by one cycle, traded for clean outputs
			IRQ_OUT <= |(irq_sts_r & irq_msk_r);
			FINT_BRANCH_OUT <= FINT_ACCEPT_IN;
			FP_TRAP_OUT <= fp_trap_nxt;
			PC_OUT <= pc_r;
			STW_OUT <= stw_r;
			VTB_OUT <= vtb_r;
			SP_OUT <= use_ustk ? ustk_r : istk_r;
		end
	end

	// ==========================================================
	// Checks
	// Fast interrupt: copies, branch pulse and target
	AST_SVPC_SAVE: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		FINT_ACCEPT_IN |=> svpc_r == $past(pc_r))
		else $error("saved pc not captured");
	AST_SVSTW_SAVE: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		FINT_ACCEPT_IN |=> svstw_r == $past(stw_r))
		else $error("saved status not captured");
	// Back-to-back accepts are legal, so the pulse is checked on its own
	AST_FINT_BRANCH: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		FINT_ACCEPT_IN |=> FINT_BRANCH_OUT ##1 (PC_OUT == $past(fvec_r, 2)))
		else $error("fast branch target wrong");
	AST_FINT_QUIET: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		!FINT_ACCEPT_IN |=> !FINT_BRANCH_OUT)
		else $error("fast branch pulse without accept");
	AST_PC_LOAD: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		PC_LOAD_IN.valid && !FINT_ACCEPT_IN |=> pc_r == $past(PC_LOAD_IN.value))
		else $error("program counter load lost");
	// Control words, the banked stack pointer and idle read data
	AST_VEC_BASE: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		WR_IN && ADDR_IN == CRS_A_VTB |=> vtb_r == $past(WDATA_IN))
		else $error("vector base write lost");
	AST_SP_WRITE: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		wr_sp |=> ($past(use_ustk) ? ustk_r : istk_r) == $past(WDATA_IN))
		else $error("stack pointer alias write lost");
	AST_RDATA_IDLE: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		!RD_IN |=> RDATA_OUT == 32'h0000_0000)
		else $error("read data outside its cycle");
	// Floating-point status
	AST_TRAP_ENABLED: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		(FP_EXC_IN & fp_en_r) != 5'h00 |=> FP_TRAP_OUT && fp_cause_r == $past(FP_EXC_IN))
		else $error("enabled exception did not trap");
	AST_TRAP_MASKED: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		(FP_EXC_IN & fp_en_r) == 5'h00 |=> !FP_TRAP_OUT)
		else $error("masked exception trapped");
	AST_STICKY: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		!(WR_IN && ADDR_IN == CRS_A_FPST) |=> (fp_sticky_r & $past(fp_sticky_r)) == $past(fp_sticky_r))
		else $error("sticky flag dropped");
	// Accumulator and the banked stack pointer read
	AST_MAC_OVERWRITE: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		MAC_OP_IN.valid |=> mac_r == $past(MAC_OP_IN.result))
		else $error("accumulator not overwritten");
	AST_MAC_HI_WRITE: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		WR_IN && ADDR_IN == CRS_A_MACHI && !MAC_OP_IN.valid
		|=> mac_r == {$past(WDATA_IN), $past(mac_r[31:0])})
		else $error("accumulator high write wrong");
	AST_MAC_LO_WRITE: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		WR_IN && ADDR_IN == CRS_A_MACLO && !MAC_OP_IN.valid
		|=> mac_r == {$past(mac_r[63:32]), $past(WDATA_IN)})
		else $error("accumulator low write wrong");
	AST_MAC_HIGH_READ: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		RD_IN && ADDR_IN == CRS_A_MACHI |=> RDATA_OUT == $past(mac_r[63:32]))
		else $error("high read wrong");
	AST_MAC_MIDDLE: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		RD_IN && ADDR_IN == CRS_A_MACMI |=> RDATA_OUT == $past(mac_r[47:16]))
		else $error("middle read wrong");
	AST_SP_BANK: assert property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r)
		RD_IN && ADDR_IN == CRS_A_GPR0 |=> RDATA_OUT == ($past(use_ustk) ? $past(ustk_r) : $past(istk_r)))
		else $error("stack pointer bank wrong");
	// Main scenarios
	COV_FINT: cover property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r) FINT_ACCEPT_IN);
	COV_TRAP: cover property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r) FP_TRAP_OUT);
	COV_USTK: cover property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r) wr_sp && use_ustk);
	COV_MASKED: cover property (@(posedge SYS_CLK_IN) disable iff (!rst_n_r) ev_nxt[CRS_EV_FPMSK]);

endmodule // crs_register_set
`default_nettype wire

// ### bench/crs_exec_model.sv
// Execution unit and interrupt sequencer model driving the register set.
`timescale 1ns/1ps
`default_nettype none
module crs_exec_model (
	input wire logic clk_in, // System clock
	output var crs_pkg::crs_load_t pc_load_out, // Program counter load
	output var logic fint_accept_out, // Fast interrupt accepted
	output var crs_pkg::crs_mac_t mac_op_out, // Product instruction retires
	output var logic [4:0] fp_exc_out // FP exceptions of one op
);
	import crs_pkg::*;
	// ==========================================================
	// Idle state
	// Payloads start at zero; load and product payloads idle inverted after a request, FP exceptions back at zero, so a stale value never passes for a live one
	initial begin
		pc_load_out = '0;
		fint_accept_out = 1'b0;
		mac_op_out = '0;
		fp_exc_out = 5'h00;
	end
	// ==========================================================
	// One-cycle requests, changed just after an edge
	task automatic load_pc(input logic [31:0] v);
		@(posedge clk_in);
		pc_load_out <= '{valid: 1'b1, value: v};
		@(posedge clk_in);
		pc_load_out <= '{valid: 1'b0, value: ~v};
	endtask
	task automatic fint();
		@(posedge clk_in);
		fint_accept_out <= 1'b1;
		@(posedge clk_in);
		fint_accept_out <= 1'b0;
	endtask
	task automatic mac(input logic [63:0] v);
		@(posedge clk_in);
		mac_op_out <= '{valid: 1'b1, result: v};
		@(posedge clk_in);
		mac_op_out <= '{valid: 1'b0, result: ~v};
	endtask
	task automatic fp(input logic [4:0] e);
		@(posedge clk_in);
		fp_exc_out <= e;
		@(posedge clk_in);
		fp_exc_out <= 5'h00;
	endtask
endmodule // crs_exec_model
`default_nettype wire

// ### bench/testbench.sv
// Self-checking testbench for the CPU register set.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import crs_pkg::*;
	// ==========================================================
	// Stimulus signals
	logic clk;
	logic arst_n;
	logic [4:0] addr;
	logic [31:0] wdata;
	logic wr;
	logic rd;
	crs_load_t pc_load;
	logic fint_acc;
	crs_mac_t mac_op;
	logic [4:0] fp_exc;
	logic [31:0] rdata, pc_o, stw_o, vtb_o, sp_o;
	logic fint_br, fp_trap, irq;
	int err_count = 0;
	int samples_checked = 0;
	// ==========================================================
	// Design and far-side model
	crs_register_set u_crs_register_set (.SYS_CLK_IN(clk), .ARST_N_IN(arst_n),
		.ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd),
		.PC_LOAD_IN(pc_load), .FINT_ACCEPT_IN(fint_acc), .MAC_OP_IN(mac_op),
		.FP_EXC_IN(fp_exc), .RDATA_OUT(rdata), .PC_OUT(pc_o), .STW_OUT(stw_o),
		.VTB_OUT(vtb_o), .SP_OUT(sp_o), .FINT_BRANCH_OUT(fint_br),
		.FP_TRAP_OUT(fp_trap), .IRQ_OUT(irq));
	crs_exec_model u_crs_exec_model (.clk_in(clk), .pc_load_out(pc_load),
		.fint_accept_out(fint_acc), .mac_op_out(mac_op), .fp_exc_out(fp_exc));
	// ==========================================================
	// Clock, 100 MHz
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// ==========================================================
	// Shared tasks
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One-cycle write strobe; data idles inverted afterwards
	task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		wdata <= ~d;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd_chk(input string nm, input logic [4:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(nm, {32'h0, rdata}, {32'h0, e});
	endtask
	// Step to just after the next edge
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	task automatic complete_run();
		$display("Comparisons %0d mismatches %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// ==========================================================
	// Hang guard
	initial begin
		#200000;
		err_count++;
		complete_run();
	end
	// ==========================================================
	// Main sequence
	initial begin
		arst_n = 1'b0;
		addr = 5'h00;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		// General registers hold distinct whole words
		for (int i = 1; i < 16; i++)
			wr_reg(5'(i), 32'ha5a5_0000 + 32'(i * 4));
		for (int i = 1; i < 16; i++)
			rd_chk("gpr", 5'(i), 32'ha5a5_0000 + 32'(i * 4));
		// Stack pointers kept as multiples of four
		wr_reg(CRS_A_ISTK, 32'h0000_0100);
		wr_reg(CRS_A_USTK, 32'h0000_0200);
		wr_reg(CRS_A_STW, 32'h0000_0000);
		rd_chk("sp_int", CRS_A_GPR0, 32'h0000_0100);
		wr_reg(CRS_A_STW, 32'h0002_0000);
		rd_chk("sp_user", CRS_A_GPR0, 32'h0000_0200);
		wr_reg(CRS_A_GPR0, 32'h0000_0300);
		rd_chk("user_sp", CRS_A_USTK, 32'h0000_0300);
		rd_chk("int_sp", CRS_A_ISTK, 32'h0000_0100);
		step();
		chk("rdata_idle", {32'h0, rdata}, 64'h0);
		chk("sp_out", {32'h0, sp_o}, 64'h300);
		chk("status_out", {32'h0, stw_o}, 64'h2_0000);
		// Vector base and an unmapped index
		wr_reg(CRS_A_VTB, 32'h0000_4000);
		rd_chk("vec_base", CRS_A_VTB, 32'h0000_4000);
		chk("vec_base_out", {32'h0, vtb_o}, 64'h4000);
		wr_reg(5'h1e, 32'hffff_ffff);
		rd_chk("unmapped", 5'h1e, 32'h0);
		// Program counter follows the executing instruction
		u_crs_exec_model.load_pc(32'h0000_1234);
		step();
		step();
		chk("pc_out", {32'h0, pc_o}, 64'h1234);
		rd_chk("pc", CRS_A_PC, 32'h0000_1234);
		// Fast interrupt with its event masked first
		wr_reg(CRS_A_FVEC, 32'h0000_8000);
		u_crs_exec_model.fint();
		#1;
		chk("fint_branch", {63'h0, fint_br}, 64'h1);
		step();
		chk("pc_fast_vec", {32'h0, pc_o}, 64'h8000);
		chk("fint_pulse", {63'h0, fint_br}, 64'h0);
		chk("irq_masked", {63'h0, irq}, 64'h0);
		rd_chk("saved_pc", CRS_A_SVPC, 32'h0000_1234);
		rd_chk("saved_status", CRS_A_SVSTW, 32'h0002_0000);
		// Port write to the counter loses to the unit's load
		fork
			wr_reg(CRS_A_PC, 32'h0000_5555);
			u_crs_exec_model.load_pc(32'h0000_2468);
		join
		rd_chk("pc_load_wins", CRS_A_PC, 32'h0000_2468);
		wr_reg(CRS_A_IRQMSK, 32'h0000_0007);
		step();
		chk("irq_on", {63'h0, irq}, 64'h1);
		rd_chk("irq_status", CRS_A_IRQST, 32'h0000_0001);
		step();
		chk("irq_clear", {63'h0, irq}, 64'h0);
		// Enabled divide-by-zero traps, masked inexact sets cause, sticky flag and masked event without trapping
		wr_reg(CRS_A_FPST, 32'h0000_0080);
		u_crs_exec_model.fp(5'h04);
		#1;
		chk("fp_trap", {63'h0, fp_trap}, 64'h1);
		u_crs_exec_model.fp(5'h01);
		#1;
		chk("fp_masked", {63'h0, fp_trap}, 64'h0);
		rd_chk("fp_status", CRS_A_FPST, 32'h0000_1481);
		rd_chk("fp_events", CRS_A_IRQST, 32'h0000_0006);
		// Clearing write beside a new exception: the exception survives
		fork
			wr_reg(CRS_A_FPST, 32'h0000_0080);
			u_crs_exec_model.fp(5'h02);
		join
		rd_chk("fp_clear", CRS_A_FPST, 32'h0000_0882);
		// Accumulator halves, middle word and product overwrite
		wr_reg(CRS_A_MACHI, 32'h1122_3344);
		wr_reg(CRS_A_MACLO, 32'h5566_7788);
		rd_chk("mac_hi", CRS_A_MACHI, 32'h1122_3344);
		rd_chk("mac_lo", CRS_A_MACLO, 32'h5566_7788);
		rd_chk("mac_mid", CRS_A_MACMI, 32'h3344_5566);
		// Product retiring beside a move-to must win
		fork
			wr_reg(CRS_A_MACHI, 32'hffff_ffff);
			u_crs_exec_model.mac(64'h0123_4567_89ab_cdef);
		join
		rd_chk("prod_hi", CRS_A_MACHI, 32'h0123_4567);
		rd_chk("prod_mid", CRS_A_MACMI, 32'h4567_89ab);
		rd_chk("prod_lo", CRS_A_MACLO, 32'h89ab_cdef);
		complete_run();
	end
endmodule // testbench
`default_nettype wire
